// [rtl/dsbs_top.sv]
// sector buffer steering: control register, drive glue, buffer addressing
// assumes host strobes are synchronous single-cycle-sampled levels on clk
`include "dsbs_defines.svh"
module dsbs_top
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// host register port
	input  wire logic               host_io_write,
	input  wire logic [7:0]         host_addr,
	input  wire dsbs_pkg::dsbs_byte_t host_wdata,
	input  wire logic               host_io_read_n,
	input  wire logic               host_dma_ack_n,
	input  wire logic               host_strobe_block,
	input  wire logic               dma_active,
	input  wire logic               control_reg_disable,
	// host data from rom
	input  wire dsbs_pkg::dsbs_byte_t rom_data,
	output dsbs_pkg::dsbs_byte_t    host_rdata_low,
	output logic                    host_rdata_low_oe_n,
	// register outputs
	output logic [1:0]              drive_select_n,
	output logic [2:0]              head_select_n,
	output logic                    boot_rom_enable,
	output logic                    boot_rom_cs_n,
	output logic                    write_in_progress,
	output logic                    controller_reset_n,
	// drive status in, controller status out
	input  wire logic               track_zero_n,
	input  wire logic               seek_done_n,
	input  wire logic               drive_ready_n,
	input  wire logic               drive_fault_n,
	input  wire logic               index_pulse_n,
	input  wire logic               step_cmd_loaded,
	output logic [4:0]              ctrl_status,
	// controller stepping outputs in, per-drive copies out
	input  wire logic               ctrl_step,
	input  wire logic               ctrl_dir,
	input  wire logic               reduced_write_current,
	input  wire logic               write_gate,
	output logic [1:0]              step_n,
	output logic [1:0]              dir_n,
	output logic [1:0]              rwc_n,
	output logic [1:0]              wgate_n,
	// interrupt
	input  wire logic               ctrl_irq,
	output logic                    host_irq_p2_n,
	// controller buffer side
	input  wire logic               buffer_request,
	input  wire logic               buffer_select_n,
	input  wire logic               byte_toggle_clk_n,
	input  wire logic               word_advance,
	input  wire logic               buf_write_n_src,
	input  wire logic               buf_read_n_src,
	output logic                    buffer_full_empty,
	output logic                    host_isolated,
	output logic                    rom_addr_advance,
	// buffer rams
	output logic [10:0]             ram_addr,
	output logic                    buf_write_strobe_n,
	output logic                    buf_read_strobe_n,
	output logic                    lo_even_sel_n,
	output logic                    hi_even_sel_n,
	output logic                    lo_odd_sel_n,
	output logic                    hi_odd_sel_n,
	output logic                    even_lane_en_n,
	output logic                    odd_lane_en_n,
	output logic                    host_low_lane_en_n,
	output logic                    host_high_lane_en_n
);
	import dsbs_pkg::*;

	parameter int ADDR_BITS = `DSBS_ADDR_BITS;

	////////////////////////////////////////////////////////////////////////
	dsbs_byte_t             ctrl_reg;
	dsbs_byte_t             next_ctrl_reg;
	logic [ADDR_BITS-1:0]   addr_cnt;
	logic [ADDR_BITS-1:0]   next_addr_cnt;
	dsbs_lane_e             lane;
	dsbs_lane_e             next_lane;
	logic                   rd_prev;
	logic                   tog_prev;
	logic                   status_gate;
	logic                   next_status_gate;
	logic                   rd_fall;
	logic                   tog_fall;
	logic [7:0]             dec_out;
	logic                   next_adv;

	assign rd_fall = rd_prev && !host_io_read_n;
	assign tog_fall = tog_prev && !byte_toggle_clk_n;

	always_comb
	begin
		next_ctrl_reg = ctrl_reg;
		if (host_io_write && host_addr == `DSBS_CTRL_OFFSET)
			next_ctrl_reg = host_wdata;
		next_lane = lane;
		if (tog_fall)
			next_lane = (lane == dsbs_even) ? dsbs_odd : dsbs_even;
		next_adv = boot_rom_enable && rd_fall;
		next_addr_cnt = addr_cnt;
		if (word_advance || next_adv)
			next_addr_cnt = addr_cnt + 1'b1;
		next_status_gate = status_gate;
		// a load in the same cycle as controller reset wins
		if (!controller_reset_n)
			next_status_gate = 1'b0;
		if (step_cmd_loaded)
			next_status_gate = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_reg <= `DSBS_CTRL_RESET;
			addr_cnt <= '0;
			lane <= dsbs_even;
			rd_prev <= 1'b1;
			tog_prev <= 1'b1;
			status_gate <= 1'b0;
			rom_addr_advance <= 1'b0;
		end
		else
		begin
			ctrl_reg <= next_ctrl_reg;
			addr_cnt <= next_addr_cnt;
			lane <= next_lane;
			rd_prev <= host_io_read_n;
			tog_prev <= byte_toggle_clk_n;
			status_gate <= next_status_gate;
			rom_addr_advance <= next_adv;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs; control outputs driven inactive when disabled
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			drive_select_n <= 2'h3;
			head_select_n <= 3'h7;
			boot_rom_enable <= 1'b0;
			boot_rom_cs_n <= 1'b1;
			write_in_progress <= 1'b0;
			controller_reset_n <= 1'b0;
			ctrl_status <= 5'h1f;
			step_n <= 2'h3;
			dir_n <= 2'h3;
			rwc_n <= 2'h3;
			wgate_n <= 2'h3;
			host_irq_p2_n <= 1'b1;
			buffer_full_empty <= 1'b0;
			host_isolated <= 1'b0;
			host_rdata_low <= 8'h00;
			host_rdata_low_oe_n <= 1'b1;
			ram_addr <= 11'h000;
			buf_write_strobe_n <= 1'b1;
			buf_read_strobe_n <= 1'b1;
			{lo_even_sel_n, hi_even_sel_n, lo_odd_sel_n, hi_odd_sel_n,
			 even_lane_en_n, odd_lane_en_n, host_low_lane_en_n,
			 host_high_lane_en_n} <= 8'hff;
		end
		else
		begin
			if (control_reg_disable)
			begin
				drive_select_n <= 2'h3;
				head_select_n <= 3'h7;
				boot_rom_enable <= 1'b0;
				boot_rom_cs_n <= 1'b1;
				write_in_progress <= 1'b0;
				controller_reset_n <= 1'b1;
			end
			else
			begin
				drive_select_n <= ~ctrl_reg[`DSBS_BIT_DSEL1:`DSBS_BIT_DSEL0];
				head_select_n <= ~ctrl_reg[`DSBS_BIT_HSEL_HI:`DSBS_BIT_HSEL_LO];
				boot_rom_enable <= ctrl_reg[`DSBS_BIT_BOOT];
				boot_rom_cs_n <= !ctrl_reg[`DSBS_BIT_BOOT];
				write_in_progress <= ctrl_reg[`DSBS_BIT_WRITE];
				controller_reset_n <= !ctrl_reg[`DSBS_BIT_RESET];
			end
			// status held inactive until a stepping command is loaded
			ctrl_status <= status_gate ? {~seek_done_n, ~track_zero_n,
				~drive_fault_n, ~index_pulse_n, ~drive_ready_n} : 5'h00;
			// low only where the signal is set and that drive is selected
			step_n <= ~{2{ctrl_step}} | drive_select_n;
			dir_n <= ~{2{ctrl_dir}} | drive_select_n;
			rwc_n <= ~{2{reduced_write_current}} | drive_select_n;
			wgate_n <= ~{2{write_gate}} | drive_select_n;
			host_irq_p2_n <= !ctrl_irq;
			buffer_full_empty <= write_in_progress;
			host_isolated <= !buffer_select_n
				|| (host_strobe_block && !dma_active);
			host_rdata_low <= rom_data;
			host_rdata_low_oe_n <= !(boot_rom_enable && dma_active
				&& !host_io_read_n);
			ram_addr <= addr_cnt[`DSBS_RAM_ADDR_BITS-1:0];
			buf_write_strobe_n <= buf_write_n_src;
			buf_read_strobe_n <= buf_read_n_src;
			{lo_even_sel_n, hi_even_sel_n, lo_odd_sel_n, hi_odd_sel_n,
			 even_lane_en_n, odd_lane_en_n, host_low_lane_en_n,
			 host_high_lane_en_n} <= dec_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	dsbs_decoder u_dec
	(
		.buffer_select       (!buffer_select_n),
		.buffer_request      (buffer_request),
		.host_ack            (!host_dma_ack_n),
		.upper_byte_sel      (lane == dsbs_odd),
		.bank_msb            (addr_cnt[`DSBS_RAM_ADDR_BITS]),
		.lo_even_sel_n       (dec_out[7]),
		.hi_even_sel_n       (dec_out[6]),
		.lo_odd_sel_n        (dec_out[5]),
		.hi_odd_sel_n        (dec_out[4]),
		.even_lane_en_n      (dec_out[3]),
		.odd_lane_en_n       (dec_out[2]),
		.host_low_lane_en_n  (dec_out[1]),
		.host_high_lane_en_n (dec_out[0])
	);
endmodule

// [rtl/dsbs_defines.svh]
// offsets, field positions and reset values for the sector buffer steering
// assumes inclusion from the design files by bare name
//
// Notes on behaviour
// - control bit 2 enables the 4K boot rom for host reads.
// - control bit 6 marks write in progress, drives controller buffer ready.
// - control bit 7 drives the active-low controller reset.
// - control outputs are disabled while control_reg_disable is asserted.
// - drive status lines pass through to controller after a stepping command.
// - step, direction, write current, write gate inverted, one copy per drive.
// - controller interrupt raises the active-low priority 2 host interrupt.
// - each host read with rom enabled pulses the address advance.
// - buffer is four 2K by 8 rams, two even, two odd.
// - rams get eleven low address bits and shared read/write strobes.
// - controller select picks lower even ram and even transceiver.
// - byte toggle pulse flips even/odd state; odd picks odd ram and lane.
// - each word advances the counter; top bit selects upper ram pair.
// - controller request gates host dma word transfers; host ack inverted to decoder.
// - acknowledged host dma moves 16-bit words on two lane enables.
// - while controller owns the buffer the host bus is isolated.
`ifndef DSBS_DEFINES_SVH
`define DSBS_DEFINES_SVH
`define DSBS_CTRL_OFFSET   8'h0a
`define DSBS_BIT_DSEL0     0
`define DSBS_BIT_DSEL1     1
`define DSBS_BIT_BOOT      2
`define DSBS_BIT_HSEL_LO   3
`define DSBS_BIT_HSEL_HI   5
`define DSBS_BIT_WRITE     6
`define DSBS_BIT_RESET     7
`define DSBS_CTRL_RESET    8'h00
`define DSBS_ADDR_BITS     12
`define DSBS_RAM_ADDR_BITS 11
`endif

// [rtl/dsbs_pkg.sv]
// types shared by the sector buffer steering files
// assumes the defines header is visible on the include path
package dsbs_pkg;
	typedef logic [7:0] dsbs_byte_t;
	typedef enum logic [0:0] {dsbs_even, dsbs_odd} dsbs_lane_e;
endpackage

// [rtl/dsbs_decoder.sv]
// buffer chip select and lane decoder, combinational
// assumes all inputs synchronous and active high except noted
`include "dsbs_defines.svh"
module dsbs_decoder
(
	// access sources
	input  wire logic buffer_select,
	input  wire logic buffer_request,
	input  wire logic host_ack,
	input  wire logic upper_byte_sel,
	input  wire logic bank_msb,
	// selects, active low
	output logic      lo_even_sel_n,
	output logic      hi_even_sel_n,
	output logic      lo_odd_sel_n,
	output logic      hi_odd_sel_n,
	output logic      even_lane_en_n,
	output logic      odd_lane_en_n,
	output logic      host_low_lane_en_n,
	output logic      host_high_lane_en_n
);
	logic ctl_acc;
	logic dma_acc;

	always_comb
	begin
		// controller byte access has priority over host dma
		ctl_acc = buffer_select;
		dma_acc = !buffer_select && buffer_request && host_ack;
		lo_even_sel_n = 1'b1;
		hi_even_sel_n = 1'b1;
		lo_odd_sel_n = 1'b1;
		hi_odd_sel_n = 1'b1;
		even_lane_en_n = 1'b1;
		odd_lane_en_n = 1'b1;
		host_low_lane_en_n = 1'b1;
		host_high_lane_en_n = 1'b1;
		if (ctl_acc)
		begin
			if (!upper_byte_sel)
			begin
				lo_even_sel_n = bank_msb;
				hi_even_sel_n = !bank_msb;
				even_lane_en_n = 1'b0;
			end
			else
			begin
				lo_odd_sel_n = bank_msb;
				hi_odd_sel_n = !bank_msb;
				odd_lane_en_n = 1'b0;
			end
		end
		else if (dma_acc)
		begin
			lo_even_sel_n = bank_msb;
			hi_even_sel_n = !bank_msb;
			lo_odd_sel_n = bank_msb;
			hi_odd_sel_n = !bank_msb;
			host_low_lane_en_n = 1'b0;
			host_high_lane_en_n = 1'b0;
		end
	end
endmodule

// [test/dsbs_top_assertions.sv]
// port checker for the sector buffer steering top
// assumes one clock domain, bound onto dsbs_top by port name
module dsbs_top_assertions
(
	// clock and reset
	input wire logic	clk,
	input wire logic	reset_n,
	// causes
	input wire logic	host_io_read_n,
	input wire logic	host_dma_ack_n,
	input wire logic	host_strobe_block,
	input wire logic	dma_active,
	input wire logic	control_reg_disable,
	input wire logic	ctrl_irq,
	input wire logic	buffer_request,
	input wire logic	buffer_select_n,
	input wire logic	word_advance,
	// effects
	input wire logic	boot_rom_enable,
	input wire logic	boot_rom_cs_n,
	input wire logic	write_in_progress,
	input wire logic	controller_reset_n,
	input wire logic	host_irq_p2_n,
	input wire logic	host_isolated,
	input wire logic	rom_addr_advance,
	input wire logic [10:0]	ram_addr,
	input wire logic	lo_even_sel_n,
	input wire logic	hi_even_sel_n,
	input wire logic	lo_odd_sel_n,
	input wire logic	hi_odd_sel_n,
	input wire logic	even_lane_en_n,
	input wire logic	odd_lane_en_n,
	input wire logic	host_low_lane_en_n,
	input wire logic	host_high_lane_en_n
);
////////////////////////////////////////
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire	all_off = &{lo_even_sel_n, hi_even_sel_n, lo_odd_sel_n,
		hi_odd_sel_n, even_lane_en_n, odd_lane_en_n,
		host_low_lane_en_n, host_high_lane_en_n};
	boot_cs_a: assert property (boot_rom_cs_n == !boot_rom_enable)
		else $error("boot select off enable");
	irq_pass_a: assert property ($past(reset_n) |->
		host_irq_p2_n == !$past(ctrl_irq)) else $error("irq wrong");
	reg_off_a: assert property (control_reg_disable [*2] |=>
		!boot_rom_enable && !write_in_progress && controller_reset_n)
		else $error("disable ignored");
	rom_step_a: assert property ($fell(host_io_read_n) &&
		boot_rom_enable |=> rom_addr_advance ##1 !rom_addr_advance)
		else $error("rom advance wrong");
	// one word pulse, nothing else moving the counter
	word_step_a: assert property (word_advance && !$past(word_advance)
		&& !rom_addr_advance |-> ##2 ram_addr == $past(ram_addr) + 11'h1)
		else $error("counter step wrong");
	ctrl_sel_a: assert property (!buffer_select_n |=>
		(even_lane_en_n ^ odd_lane_en_n) && host_low_lane_en_n &&
		host_high_lane_en_n) else $error("controller lanes wrong");
	idle_off_a: assert property (buffer_select_n &&
		!(buffer_request && !host_dma_ack_n) |=> all_off)
		else $error("select while idle");
	dma_lane_a: assert property (buffer_select_n && buffer_request
		&& !host_dma_ack_n |=> !host_low_lane_en_n && !host_high_lane_en_n
		&& even_lane_en_n && odd_lane_en_n) else $error("dma lanes wrong");
	isolate_a: assert property (!buffer_select_n ||
		host_strobe_block && !dma_active |=> host_isolated)
		else $error("host not isolated");
	cover property (rom_addr_advance);
	cover property (!lo_odd_sel_n);
	cover property (!hi_even_sel_n);
	cover property (!host_low_lane_en_n);
endmodule
bind dsbs_top dsbs_top_assertions chk_u (.*);

// [test/dsbs_host_model.sv]
// host bus master: control writes, boot rom reads, dma acknowledge
// assumes changes after falling edge, taken at rising edge of clk
module dsbs_host_model
(
	// clock
	input wire logic		clk,
	// host bus
	output logic			host_io_write = 1'b0,
	output logic [7:0]		host_addr = 8'h00,
	output dsbs_pkg::dsbs_byte_t	host_wdata = 8'h00,
	output logic			host_io_read_n = 1'b1,
	output logic			host_dma_ack_n = 1'b1,
	output logic			host_strobe_block = 1'b0,
	output logic			dma_active = 1'b0,
	input wire dsbs_pkg::dsbs_byte_t	host_rdata_low
);
	timeunit 1ns;
	timeprecision 1ps;
	import dsbs_pkg::*;
////////////////////////////////////////
	// released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input dsbs_byte_t d);
		@(negedge clk);
		host_io_write = 1'b1;
		host_addr = a;
		host_wdata = d;
		@(negedge clk);
		host_io_write = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
	endtask
	task automatic rd(output dsbs_byte_t d);
		@(negedge clk);
		host_io_read_n = 1'b0;
		repeat (4) @(negedge clk);
		d = host_rdata_low;
		host_io_read_n = 1'b1;
	endtask
	task automatic mode(input logic blk, act, ack_n);
		@(negedge clk);
		host_strobe_block = blk;
		dma_active = act;
		host_dma_ack_n = ack_n;
	endtask
endmodule

// [test/dsbs_top_bench.sv]
// self-checking bench for the sector buffer steering top
// assumes host model drives the host bus, checker bound to the design
module dsbs_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dsbs_pkg::*;
////////////////////////////////////////
	logic clk = 0, reset_n = 0, control_reg_disable = 0, step_cmd_loaded = 0;
	logic track_zero_n = 1, seek_done_n = 1, drive_ready_n = 1;
	logic drive_fault_n = 1, index_pulse_n = 1, ctrl_irq = 0;
	logic ctrl_step = 0, ctrl_dir = 0, reduced_write_current = 0;
	logic write_gate = 0, buffer_request = 0, buffer_select_n = 1;
	logic byte_toggle_clk_n = 1, word_advance = 0;
	logic buf_write_n_src = 1, buf_read_n_src = 1;
	dsbs_byte_t rom_data = 8'h00, host_rdata_low, host_wdata, rd_val;
	logic host_io_write, host_io_read_n, host_dma_ack_n, host_strobe_block;
	logic dma_active, host_rdata_low_oe_n, boot_rom_enable, boot_rom_cs_n;
	logic write_in_progress, controller_reset_n, host_irq_p2_n;
	logic buffer_full_empty, host_isolated, rom_addr_advance;
	logic buf_write_strobe_n, buf_read_strobe_n, lo_even_sel_n;
	logic hi_even_sel_n, lo_odd_sel_n, hi_odd_sel_n, even_lane_en_n;
	logic odd_lane_en_n, host_low_lane_en_n, host_high_lane_en_n;
	logic [1:0] drive_select_n, step_n, dir_n, rwc_n, wgate_n;
	logic [2:0] head_select_n;
	logic [4:0] ctrl_status;
	logic [7:0] host_addr;
	logic [10:0] ram_addr;
	int error_cnt = 0, cmp_count = 0, adv_cnt = 0;
	wire [5:0] sels = {lo_even_sel_n, hi_even_sel_n, lo_odd_sel_n,
		hi_odd_sel_n, even_lane_en_n, odd_lane_en_n};
	dsbs_top dut_u (.*);
	dsbs_host_model host_u (.*);
	always #2 clk = ~clk;
	always @(posedge clk)
		if (rom_addr_advance === 1'b1)
			adv_cnt++;
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [15:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one falling edge of the toggle clock flips the byte lane
	task automatic toggle;
		byte_toggle_clk_n = 1'b0;
		tick(1);
		byte_toggle_clk_n = 1'b1;
		tick(3);
	endtask
	initial
	begin
		#60000;
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		tick(2);
		chk({controller_reset_n, ctrl_status}, 6'h1f);
		reset_n = 1'b1;
		tick(1);
		chk(ctrl_status, 0);
		host_u.wr(8'h0a, 8'h01);
		tick(2);
		step_cmd_loaded = 1'b1;
		tick(1);
		step_cmd_loaded = 1'b0;
		track_zero_n = 1'b0;
		tick(3);
		chk(ctrl_status, 5'b01000);
		{seek_done_n, index_pulse_n} = 2'b00;
		tick(2);
		chk(ctrl_status, 5'b11010);
		{ctrl_step, ctrl_dir, reduced_write_current, write_gate} = 4'hf;
		for (int d = 0; d < 2; d++)
		begin
			host_u.wr(8'h0a, 8'h28 | (8'h01 << d));
			tick(2);
			chk({step_n, dir_n, rwc_n, wgate_n}, {4{~(2'b01 << d)}});
			chk({drive_select_n, head_select_n},
				{~(2'b01 << d), 3'b010});
		end
		// an unmapped offset must leave the register alone
		host_u.wr(8'h0b, 8'hc4);
		tick(2);
		chk({boot_rom_enable, head_select_n}, 4'b0010);
		host_u.wr(8'h0a, 8'hc4);
		tick(2);
		chk({boot_rom_enable, boot_rom_cs_n, write_in_progress,
			controller_reset_n}, 4'b1010);
		tick(3);
		chk({buffer_full_empty, ctrl_status}, 6'h20);
		rom_data = 8'h5a;
		host_u.mode(1'b0, 1'b1, 1'b1);
		repeat (2)
		begin
			host_u.rd(rd_val);
			chk({host_rdata_low_oe_n, rd_val}, {1'b0, 8'h5a});
			tick(2);
		end
		chk({adv_cnt[3:0], ram_addr}, {4'h2, 11'h2});
		control_reg_disable = 1'b1;
		tick(3);
		chk({boot_rom_enable, write_in_progress, controller_reset_n}, 1);
		control_reg_disable = 1'b0;
		ctrl_irq = 1'b1;
		tick(2);
		chk(host_irq_p2_n, 0);
		ctrl_irq = 1'b0;
		tick(2);
		chk(host_irq_p2_n, 1);
		buffer_select_n = 1'b0;
		buf_read_n_src = 1'b0;
		tick(2);
		chk(sels, 6'b011101);
		chk({buf_write_strobe_n, buf_read_strobe_n, host_isolated},
			3'b101);
		toggle();
		chk(sels, 6'b110110);
		{buf_write_n_src, buf_read_n_src} = 2'b01;
		repeat (2048)
		begin
			word_advance = 1'b1;
			tick(1);
			word_advance = 1'b0;
			tick(1);
		end
		tick(2);
		chk({sels, buf_write_strobe_n, buf_read_strobe_n},
			8'b11101001);
		toggle();
		chk({sels, ram_addr}, {6'b101101, 11'h2});
		buffer_select_n = 1'b1;
		{buf_write_n_src, buf_read_n_src} = 2'b11;
		host_u.mode(1'b1, 1'b0, 1'b1);
		tick(2);
		chk(host_isolated, 1);
		buffer_request = 1'b1;
		host_u.mode(1'b0, 1'b1, 1'b0);
		tick(2);
		chk({host_isolated, host_low_lane_en_n, host_high_lane_en_n}, 0);
		host_u.mode(1'b0, 1'b1, 1'b1);
		tick(2);
		chk({sels, host_low_lane_en_n, host_high_lane_en_n}, 8'hff);
		report_and_stop();
	end
endmodule
